// ===== shared/tam_pkg.sv
// Constants, reset values and carriers for the alarm mask and limit bank.
// Assumes one system clock and a command-byte register port behind the
// two-wire bus front end, which lives outside this block.
//
// What this block does
// - Mask bit one blocks event, zero passes.
// - Mask bits map remote4, remote3, remote2, remote1, local.
// - First mask at 0x0C, resets to 0x19.
// - Second mask at 0x0D, reset 0x00, second-limit.
// - Third mask at 0x0E, reset 0x07, second-limit.
// - Mask bits 7-5 read zero, ignore writes.
// - Local limit at 0x40, reset 0x55, 0-127.
// - Local limit bit 7 always reads zero.
// - Local reading compared against local limit.
// - Set at limit, clear below limit minus hysteresis.
// - Output active while any unmasked status set.
package tam_pkg;

  // ==========================================================
  // Widths
  localparam int TAM_DATA_W = 8;
  localparam int TAM_MASK_W = 5;
  localparam int TAM_LIMIT_W = 7;
  localparam int TAM_HYST_W = 5;
  localparam int TAM_NUM_ALARM = 3;

  // ==========================================================
  // Command codes
  localparam logic [7:0] TAM_CMD_MASK1 = 8'h0C;
  localparam logic [7:0] TAM_CMD_MASK2 = 8'h0D;
  localparam logic [7:0] TAM_CMD_MASK3 = 8'h0E;
  localparam logic [7:0] TAM_CMD_LIMIT = 8'h40;
  localparam logic [7:0] TAM_MASK_CMD [TAM_NUM_ALARM] =
    '{TAM_CMD_MASK1, TAM_CMD_MASK2, TAM_CMD_MASK3};

  // ==========================================================
  // Reset values
  localparam logic [4:0] TAM_MASK1_RST = 5'h19;
  localparam logic [4:0] TAM_MASK2_RST = 5'h00;
  localparam logic [4:0] TAM_MASK3_RST = 5'h07;
  localparam logic [4:0] TAM_MASK_RST [TAM_NUM_ALARM] =
    '{TAM_MASK1_RST, TAM_MASK2_RST, TAM_MASK3_RST};
  localparam logic [6:0] TAM_LIMIT_RST = 7'h55;
  localparam logic [7:0] TAM_ZERO_BYTE = 8'h00;
  localparam logic [4:0] TAM_MASK_ALL = 5'h1F;

  // ==========================================================
  // Types
  typedef logic [TAM_MASK_W-1:0] tam_mask_t;

  // Bit order matches the mask layout: remote4 high, local low
  typedef struct packed {
    logic remote4;
    logic remote3;
    logic remote2;
    logic remote1;
    logic local_ch;
  } tam_chan_s;

  typedef struct packed {
    logic remote4;
    logic remote3;
    logic remote2_first;
    logic remote1_first;
    logic remote2_second;
    logic remote1_second;
  } tam_remote_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } tam_req_s;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } tam_rsp_s;

endpackage

// ===== hdl/tam_bank.sv
// Alarm mask registers, local limit register, local status and the three
// active-low critical alarm outputs.
// Assumes remote status bits, hysteresis and local reading come from logic
// on the same clock, and the bus front end issues one-cycle strobes.
`timescale 1ns/100ps
module tam_bank (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire tam_pkg::tam_req_s req_i,
  output tam_pkg::tam_rsp_s rsp_o,
  input wire logic [7:0] local_temp_i,
  input wire logic local_temp_valid_i,
  input wire tam_pkg::tam_remote_s remote_evt_i,
  input wire logic [4:0] hyst_i,
  output logic local_status_o,
  output logic crit_alarm_out1_n_o,
  output logic crit_alarm_out2_n_o,
  output logic crit_alarm_out3_n_o
);

  // ==========================================================
  // Storage
  tam_pkg::tam_mask_t mask_reg [tam_pkg::TAM_NUM_ALARM];
  tam_pkg::tam_chan_s stat [tam_pkg::TAM_NUM_ALARM];
  logic [6:0] limit_reg;
  logic local_stat_reg;
  logic [2:0] alarm_n_reg;
  tam_pkg::tam_rsp_s rsp_reg;
  logic [7:0] rdata_next;
  logic [8:0] temp_ext;
  logic [8:0] temp_plus_hyst;
  logic [8:0] limit_ext;

  // ==========================================================
  // Mask registers and alarm outputs, one per alarm
  genvar gi;
  generate
    for (gi = 0; gi < tam_pkg::TAM_NUM_ALARM; gi++) begin : g_alarm
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          mask_reg[gi] <= tam_pkg::TAM_MASK_RST[gi];
        end else if (req_i.wr &&
                     req_i.cmd == tam_pkg::TAM_MASK_CMD[gi]) begin
          mask_reg[gi] <= req_i.wdata[tam_pkg::TAM_MASK_W-1:0];
        end
      end

      // mask one blocks, any unmasked bit fires
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          alarm_n_reg[gi] <= 1'b1;
        end else begin
          alarm_n_reg[gi] <= ~|(stat[gi] & ~mask_reg[gi]);
        end
      end
    end
  endgenerate

  // ==========================================================
  // Status routing
  // first output uses first limits, others second
  always_comb begin
    stat[0] = '{remote4: remote_evt_i.remote4,
                remote3: remote_evt_i.remote3,
                remote2: remote_evt_i.remote2_first,
                remote1: remote_evt_i.remote1_first,
                local_ch: local_stat_reg};
    stat[1] = '{remote4: remote_evt_i.remote4,
                remote3: remote_evt_i.remote3,
                remote2: remote_evt_i.remote2_second,
                remote1: remote_evt_i.remote1_second,
                local_ch: local_stat_reg};
    stat[2] = stat[1];
  end

  // ==========================================================
  // Local limit register
  // seven bits kept, bit 7 dropped
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      limit_reg <= tam_pkg::TAM_LIMIT_RST;
    end else if (req_i.wr && req_i.cmd == tam_pkg::TAM_CMD_LIMIT) begin
      limit_reg <= req_i.wdata[tam_pkg::TAM_LIMIT_W-1:0];
    end
  end

  // ==========================================================
  // Local status with hysteresis
  // Adding hysteresis to the reading avoids underflow of limit minus hyst
  assign temp_ext = {1'b0, local_temp_i};
  assign temp_plus_hyst = temp_ext + {4'h0, hyst_i};
  assign limit_ext = {2'b00, limit_reg};

  // set at limit, clear below limit minus hysteresis
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      local_stat_reg <= 1'b0;
    end else if (local_temp_valid_i) begin
      if (temp_ext >= limit_ext) begin
        local_stat_reg <= 1'b1;
      end else if (temp_plus_hyst < limit_ext) begin
        local_stat_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read path; unmapped codes read zero
  // reserved bits padded with zero
  always_comb begin
    case (req_i.cmd)
      tam_pkg::TAM_CMD_MASK1: rdata_next = {3'b000, mask_reg[0]};
      tam_pkg::TAM_CMD_MASK2: rdata_next = {3'b000, mask_reg[1]};
      tam_pkg::TAM_CMD_MASK3: rdata_next = {3'b000, mask_reg[2]};
      tam_pkg::TAM_CMD_LIMIT: rdata_next = {1'b0, limit_reg};
      default: rdata_next = tam_pkg::TAM_ZERO_BYTE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.ack <= req_i.rd;
      if (req_i.rd) begin
        rsp_reg.rdata <= rdata_next;
      end
    end
  end

  assign rsp_o = rsp_reg;
  assign local_status_o = local_stat_reg;
  assign crit_alarm_out1_n_o = alarm_n_reg[0];
  assign crit_alarm_out2_n_o = alarm_n_reg[1];
  assign crit_alarm_out3_n_o = alarm_n_reg[2];

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  logic [7:0] rd_cmd_reg;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_cmd_reg <= tam_pkg::TAM_ZERO_BYTE;
    end else if (req_i.rd) begin
      rd_cmd_reg <= req_i.cmd;
    end
  end

  property p_all_masked_quiet;
    (mask_reg[0] == tam_pkg::TAM_MASK_ALL) |=> crit_alarm_out1_n_o;
  endproperty
  a_all_masked_quiet: assert property (p_all_masked_quiet)
    else $error("Fully masked first alarm went active");

  property p_local_reaches_out1;
    (local_stat_reg && !mask_reg[0][0]) |=> !crit_alarm_out1_n_o;
  endproperty
  a_local_reaches_out1: assert property (p_local_reaches_out1)
    else $error("Unmasked local status did not reach first alarm");

  property p_mask1_reset;
    $past(sys_rst_i) |-> mask_reg[0] == tam_pkg::TAM_MASK1_RST;
  endproperty
  a_mask1_reset: assert property (p_mask1_reset)
    else $error("First mask reset value wrong");

  property p_mask2_r2_second;
    (remote_evt_i.remote2_second && !mask_reg[1][2])
      |=> !crit_alarm_out2_n_o;
  endproperty
  a_mask2_r2_second: assert property (p_mask2_r2_second)
    else $error("Remote2 second-limit event lost on second alarm");

  property p_mask3_reset;
    $past(sys_rst_i) |-> mask_reg[2] == tam_pkg::TAM_MASK3_RST;
  endproperty
  a_mask3_reset: assert property (p_mask3_reset)
    else $error("Third mask reset value wrong");

  property p_mask_rsv_zero;
    (rsp_o.ack && (rd_cmd_reg == tam_pkg::TAM_CMD_MASK1 ||
                   rd_cmd_reg == tam_pkg::TAM_CMD_MASK2 ||
                   rd_cmd_reg == tam_pkg::TAM_CMD_MASK3))
      |-> rsp_o.rdata[7:5] == 3'b000;
  endproperty
  a_mask_rsv_zero: assert property (p_mask_rsv_zero)
    else $error("Mask reserved bits read non-zero");

  property p_limit_write;
    (req_i.wr && req_i.cmd == tam_pkg::TAM_CMD_LIMIT)
      |=> limit_reg == $past(req_i.wdata[6:0]);
  endproperty
  a_limit_write: assert property (p_limit_write)
    else $error("Local limit write not stored");

  property p_limit_bit7;
    req_i.rd && req_i.cmd == tam_pkg::TAM_CMD_LIMIT
      ##1 rsp_o.ack |-> !rsp_o.rdata[7] &&
      rsp_o.rdata[6:0] == $past(limit_reg);
  endproperty
  a_limit_bit7: assert property (p_limit_bit7)
    else $error("Local limit readback wrong");

  property p_local_set;
    (local_temp_valid_i && temp_ext >= limit_ext) |=> local_stat_reg;
  endproperty
  a_local_set: assert property (p_local_set)
    else $error("Local status not set at limit");

  property p_local_hold;
    (local_stat_reg && local_temp_valid_i && temp_plus_hyst >= limit_ext)
      |=> local_stat_reg;
  endproperty
  a_local_hold: assert property (p_local_hold)
    else $error("Local status cleared inside hysteresis band");

  property p_all_clear_release;
    (stat[2] == '0) [*2] |-> crit_alarm_out3_n_o;
  endproperty
  a_all_clear_release: assert property (p_all_clear_release)
    else $error("Third alarm active with no status set");

  property p_reset_inactive;
    $past(sys_rst_i) |-> alarm_n_reg == 3'b111;
  endproperty
  a_reset_inactive: assert property (p_reset_inactive)
    else $error("Alarm outputs not inactive after reset");

  property p_mask1_write;
    (req_i.wr && req_i.cmd == tam_pkg::TAM_CMD_MASK1)
      |=> mask_reg[0] == $past(req_i.wdata[tam_pkg::TAM_MASK_W-1:0]);
  endproperty
  a_mask1_write: assert property (p_mask1_write)
    else $error("First mask write not stored");

  property p_mask2_write;
    (req_i.wr && req_i.cmd == tam_pkg::TAM_CMD_MASK2)
      |=> mask_reg[1] == $past(req_i.wdata[tam_pkg::TAM_MASK_W-1:0]);
  endproperty
  a_mask2_write: assert property (p_mask2_write)
    else $error("Second mask write not stored");

  property p_mask3_write;
    (req_i.wr && req_i.cmd == tam_pkg::TAM_CMD_MASK3)
      |=> mask_reg[2] == $past(req_i.wdata[tam_pkg::TAM_MASK_W-1:0]);
  endproperty
  a_mask3_write: assert property (p_mask3_write)
    else $error("Third mask write not stored");

  property p_mask2_reset;
    $past(sys_rst_i) |-> mask_reg[1] == tam_pkg::TAM_MASK2_RST;
  endproperty
  a_mask2_reset: assert property (p_mask2_reset)
    else $error("Second mask reset value wrong");

  property p_limit_reset;
    $past(sys_rst_i) |-> limit_reg == tam_pkg::TAM_LIMIT_RST;
  endproperty
  a_limit_reset: assert property (p_limit_reset)
    else $error("Local limit reset value wrong");

  property p_local_clear;
    (local_temp_valid_i && temp_plus_hyst < limit_ext) |=> !local_stat_reg;
  endproperty
  a_local_clear: assert property (p_local_clear)
    else $error("Local status not cleared below hysteresis band");

  // Status must not drift while no reading is offered
  property p_local_idle_hold;
    !local_temp_valid_i |=> $stable(local_stat_reg);
  endproperty
  a_local_idle_hold: assert property (p_local_idle_hold)
    else $error("Local status changed without a valid reading");

  property p_out1_first_limit;
    (remote_evt_i.remote2_first && !mask_reg[0][2])
      |=> !crit_alarm_out1_n_o;
  endproperty
  a_out1_first_limit: assert property (p_out1_first_limit)
    else $error("Remote2 first-limit event lost on first alarm");

  property p_out3_r1_second;
    (remote_evt_i.remote1_second && !mask_reg[2][1])
      |=> !crit_alarm_out3_n_o;
  endproperty
  a_out3_r1_second: assert property (p_out3_r1_second)
    else $error("Remote1 second-limit event lost on third alarm");

  property p_r4_reaches_out3;
    (remote_evt_i.remote4 && !mask_reg[2][4])
      |=> !crit_alarm_out3_n_o;
  endproperty
  a_r4_reaches_out3: assert property (p_r4_reaches_out3)
    else $error("Unmasked remote4 event did not reach third alarm");

  c_local_out2: cover property (local_stat_reg ##1 !crit_alarm_out2_n_o);
  c_unmask_out1: cover property (
    (req_i.wr && req_i.cmd == tam_pkg::TAM_CMD_MASK1) ##[1:4]
    !crit_alarm_out1_n_o);
  c_hyst_clear: cover property (local_stat_reg ##1 !local_stat_reg);
  c_limit_read: cover property (
    req_i.rd && req_i.cmd == tam_pkg::TAM_CMD_LIMIT ##1 rsp_o.ack);

endmodule

// ===== test/tam_host_model.sv
// Host model driving the command-byte register port of the bank.
// Assumes the caller enters its task just after a rising clock edge.
`timescale 1ns/100ps
module tam_host_model (
  input wire logic clk_i,
  input wire tam_pkg::tam_rsp_s rsp_i,
  output tam_pkg::tam_req_s req_o
);
  initial req_o = '0;
  // ==========================================================
  // One transfer
  // Released lines show a changed pattern, not the last value
  task automatic xfer(input logic w, input logic [7:0] c,
    input logic [7:0] d, output logic [7:0] q, output logic ak);
    req_o = '{wr: w, rd: !w, cmd: c, wdata: d};
    @(posedge clk_i);
    #10;
    q = rsp_i.rdata;
    ak = rsp_i.ack;
    req_o = '{wr: 1'b0, rd: 1'b0, cmd: ~c, wdata: ~d};
    // One idle edge keeps two requests out of one time step
    @(posedge clk_i);
    #10;
  endtask
endmodule

// ===== test/tb_thermal_alarm_mask_limit.sv
// Self-checking bench for the alarm mask and limit bank.
// Assumes the host model on the register port and a 10 MHz clock.
`timescale 1ns/100ps
module tb_thermal_alarm_mask_limit;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  tam_pkg::tam_req_s req;
  tam_pkg::tam_rsp_s rsp;
  logic [7:0] temp = 8'h00;
  logic valid = 1'b0;
  tam_pkg::tam_remote_s evt = '0;
  logic [4:0] hyst = 5'h00;
  logic stat;
  logic [2:0] out_n;
  logic [4:0] m [3] = '{5'h19, 5'h00, 5'h07};
  logic [7:0] cmds [5] = '{8'h0C, 8'h0D, 8'h0E, 8'h40, 8'h5A};
  logic [7:0] rstv [5] = '{8'h19, 8'h00, 8'h07, 8'h55, 8'h00};
  logic [7:0] tt [6] = '{8'h3F, 8'h40, 8'h3B, 8'h00, 8'h3A, 8'h7F};
  logic [5:0] vv = 6'b010111;
  logic [5:0] ss = 6'b001110;
  logic [7:0] q, d, lim, ev;
  logic ak, loc;
  int j;
  int failures = 0;
  int checks = 0;
  int seed = 32'he8c5c3e7;
  always #50 clk_i = ~clk_i;
  tam_host_model i_host (.clk_i(clk_i), .rsp_i(rsp), .req_o(req));
  tam_bank i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req),
    .rsp_o(rsp), .local_temp_i(temp), .local_temp_valid_i(valid),
    .remote_evt_i(evt), .hyst_i(hyst), .local_status_o(stat),
    .crit_alarm_out1_n_o(out_n[0]), .crit_alarm_out2_n_o(out_n[1]),
    .crit_alarm_out3_n_o(out_n[2]));
  // ==========================================================
  // Helpers
  task automatic chk(input string nm, input logic [7:0] seen,
    input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] v);
    logic a;
    i_host.xfer(1'b0, c, 8'h00, v, a);
    chk("read ack", {7'h00, a}, 8'h01);
  endtask
  // Remote pair bits differ: out1 takes first-limit, out2/out3 second
  function automatic logic [2:0] exp_out(input logic l);
    logic [4:0] s1, s2;
    s1 = {evt.remote4, evt.remote3, evt.remote2_first, evt.remote1_first, l};
    s2 = {evt.remote4, evt.remote3, evt.remote2_second, evt.remote1_second,
      l};
    exp_out = {~|(s2 & ~m[2]), ~|(s2 & ~m[1]), ~|(s1 & ~m[0])};
  endfunction
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    #10;
    sys_rst_i = 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(cmds[i], q);
      chk("reset value", q, rstv[i]);
    end
    lim = 8'h55;
    for (int i = 0; i < 30; i++) begin
      j = $unsigned($random(seed)) % 5;
      d = 8'($random(seed));
      // Corner: all ones into the first mask, reserved bits must drop
      if (i == 0) begin
        j = 0;
        d = 8'hFF;
      end
      i_host.xfer(1'b1, cmds[j], d, q, ak);
      if (j < 3) m[j] = d[4:0];
      if (j == 3) lim = d & 8'h7F;
      ev = j < 3 ? {3'b000, m[j]} : j == 3 ? lim : 8'h00;
      rd(cmds[j], q);
      chk("readback", q, ev);
    end
    // Limit above zero so a zero reading always clears local status
    i_host.xfer(1'b1, 8'h40, 8'h40, q, ak);
    for (int i = 0; i < 40; i++) begin
      j = $unsigned($random(seed)) % 3;
      d = 8'($random(seed));
      // Corner: first alarm fully masked while every source fires
      if (i == 0) begin
        j = 0;
        d = 8'hFF;
      end
      i_host.xfer(1'b1, cmds[j], d, q, ak);
      m[j] = d[4:0];
      evt = 6'($random(seed));
      if (i == 0) evt = '1;
      loc = d[7];
      temp = loc ? 8'hFF : 8'h00;
      valid = 1'b1;
      repeat (3) @(posedge clk_i);
      #10;
      ev = {5'h00, exp_out(loc)};
      chk("alarms", {5'h00, out_n}, ev);
    end
    evt = '0;
    hyst = 5'h05;
    // Start from a cleared local status whatever the last loop left
    temp = 8'h00;
    repeat (2) @(posedge clk_i);
    #10;
    chk("local clear", {7'h00, stat}, 8'h00);
    for (int i = 0; i < 6; i++) begin
      temp = tt[i];
      valid = vv[i];
      repeat (2) @(posedge clk_i);
      #10;
      chk("local status", {7'h00, stat}, {7'h00, ss[i]});
    end
    temp = 8'hFF;
    valid = 1'b1;
    repeat (2) @(posedge clk_i);
    #10;
    chk("local set", {7'h00, stat}, 8'h01);
    sys_rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #10;
    sys_rst_i = 1'b0;
    chk("alarms after reset", {5'h00, out_n}, 8'h07);
    chk("status after reset", {7'h00, stat}, 8'h00);
    rd(8'h0C, q);
    chk("mask after reset", q, 8'h19);
    conclude();
  end
endmodule
